/* rtl/cpt_ctrl.sv */
// CAN controller pin interface, triple transmit queue and frame sender
`timescale 1ns/1ps
module cpt_ctrl #(
  parameter logic [15:0] BIT_CYCLES = 16'(cpt_pkg::BIT_CYCLES_DEF)
) (
  input  wire logic                                   ref_clk,
  input  wire logic                                   srst,
  input  wire logic                                   ce,
  input  wire logic [cpt_pkg::PORT_W-1:0]             port_i,
  output logic      [cpt_pkg::PORT_W-1:0]             port_o,
  output logic      [cpt_pkg::PORT_W-1:0]             port_oe,
  input  wire logic [cpt_pkg::GPIO_W-1:0]             gpio_data,
  input  wire logic [cpt_pkg::GPIO_W-1:0]             gpio_dir,
  output logic      [cpt_pkg::GPIO_W-1:0]             gpio_in,
  input  wire logic                                   load,
  input  wire logic [1:0]                             load_idx,
  input  wire logic [cpt_pkg::ID_W-1:0]               load_id,
  input  wire logic                                   load_ide,
  input  wire logic                                   load_rtr,
  input  wire logic [3:0]                             load_dlc,
  input  wire logic [cpt_pkg::DATA_W-1:0]             load_data,
  input  wire logic [cpt_pkg::LOCAL_PRIORITY_FIELD_W-1:0]             load_local_priority_field,
  input  wire logic [cpt_pkg::NBUF-1:0]               mark_ready,
  output logic      [cpt_pkg::NBUF-1:0]               transmit_buffer_empty_flag,
  output logic      [cpt_pkg::NBUF-1:0]               tx_done,
  output logic                                        tx_abort
);
  import cpt_pkg::*;

  localparam logic [15:0] SAMPLE = 16'(int'(BIT_CYCLES) * SAMPLE_NUM / SAMPLE_DEN);
  localparam logic [15:0] LAST   = BIT_CYCLES - 16'h0001;

  typedef struct packed {
    cpt_state_t                      st;
    logic [15:0]                     pcnt;
    logic [6:0]                      pos;
    logic [6:0]                      len;
    logic [2:0]                      scnt;
    logic                            last;
    logic [3:0]                      idle;
    logic [1:0]                      sel;
    logic [FRAME_W-1:0]              frm;
    logic [CRC_W-1:0]                crc;
    logic                            tx;
    logic [2:0]                      rxs;
    logic                            rx;
    logic [2:0][GPIO_W-1:0]          gs;
    logic [GPIO_W-1:0]               gin;
    logic [NBUF-1:0][ID_W-1:0]       id;
    logic [NBUF-1:0]                 ide;
    logic [NBUF-1:0]                 rtr;
    logic [NBUF-1:0][3:0]            dlc;
    logic [NBUF-1:0][DATA_W-1:0]     data;
    logic [NBUF-1:0][LOCAL_PRIORITY_FIELD_W-1:0]     local_priority_field;
    logic [NBUF-1:0]                 empty;
    logic [NBUF-1:0]                 done;
    logic                            abort;
    logic [PORT_W-1:0]               po;
    logic [PORT_W-1:0]               poe;
  } cpt_regs_t;

  cpt_regs_t        r;
  cpt_regs_t        n;
  logic [NBUF-1:0]  pend;
  logic [1:0]       best;
  logic             bnd;
  logic             start;
  logic             b;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [CRC_W-1:0] crc_step(logic [CRC_W-1:0] c, logic d);
    logic [CRC_W-1:0] s;
    s = {c[CRC_W-2:0], 1'h0};
    if (d ^ c[CRC_W-1])
      s = s ^ CRC_POLY;
    return s;
  endfunction

  // Lowest local priority value wins; equal values go to the lower index
  always_comb begin
    best = 2'h0;
    for (int i = NBUF - 1; i >= 0; i--) begin
      if (pend[i] && (!pend[best] || r.local_priority_field[i] <= r.local_priority_field[best]))
        best = 2'(i);
    end
  end

  assign pend  = ~r.empty;
  assign bnd   = (r.pcnt == LAST);
  assign start = bnd && (|pend) &&
                 ((r.st == S_IDLE && r.idle == IDLE_BITS) ||
                  (r.st == S_IFS && r.pos == IFS_BITS));

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [3:0] dl;
    dl = 4'h0;
    b = RECESSIVE;
    n = r;
    n.done  = '0;
    n.abort = 1'h0;
    // Pin inputs: a change counts once the last two stages agree
    n.rxs = {r.rxs[1:0], port_i[RX_BIT]};
    if (r.rxs[1] == r.rxs[2])
      n.rx = r.rxs[2];
    n.gs  = {r.gs[1], r.gs[0], port_i[PORT_W-1:GPIO_LSB]};
    n.gin = (r.gs[2] & ~(r.gs[1] ^ r.gs[2])) | (r.gin & (r.gs[1] ^ r.gs[2]));
    // Buffer loading and ready marking only touch empty buffers
    for (int i = 0; i < NBUF; i++) begin
      if (load && load_idx == 2'(i) && r.empty[i]) begin
        n.id[i]   = load_id;
        n.ide[i]  = load_ide;
        n.rtr[i]  = load_rtr;
        n.dlc[i]  = load_dlc;
        n.data[i] = load_data;
        n.local_priority_field[i] = load_local_priority_field;
      end
      if (mark_ready[i] && r.empty[i])
        n.empty[i] = 1'h0;
    end
    n.pcnt = bnd ? 16'h0000 : 16'(r.pcnt + 16'h0001);
    // Sample point: count idle bits, or check the bus against the driven level, except the ack slot, which must read dominant
    if (r.pcnt == SAMPLE) begin
      case (r.st)
        S_IDLE: n.idle = !r.rx ? 4'h0 : (r.idle == IDLE_BITS ? r.idle : 4'(r.idle + 4'h1));
        S_FRAME, S_CRC: n.abort = (r.rx != r.tx);
        S_TAIL: n.abort = (r.pos == ACK_SLOT) ? r.rx : !r.rx;
        default: n.abort = 1'h0;
      endcase
      if (n.abort) begin
        n.st   = S_IDLE;
        n.tx   = RECESSIVE;
        n.idle = 4'h0;
      end
    end
    // Bit boundary: choose the next bit to drive
    if (start) begin
      dl     = (r.dlc[best] > MAX_DLC) ? MAX_DLC : r.dlc[best];
      n.sel  = best;
      n.st   = S_FRAME;
      n.pos  = 7'h01;
      n.tx   = DOMINANT;
      n.last = DOMINANT;
      n.scnt = 3'h1;
      n.crc  = crc_step('0, DOMINANT);
      n.len  = (r.ide[best] ? EXT_HDR : STD_HDR) + (r.rtr[best] ? 7'h00 : {dl, 3'h0});
      if (r.ide[best])
        n.frm = {r.id[best][28:18], 2'h3, r.id[best][17:0], r.rtr[best], 2'h0,
                 r.dlc[best], r.data[best], 1'h0};
      else
        n.frm = {r.id[best][10:0], r.rtr[best], 2'h0, r.dlc[best], r.data[best],
                 21'h00_0000};
    end else if (bnd) begin
      case (r.st)
        S_FRAME, S_CRC: begin
          if (r.scnt == STUFF_MAX) begin
            n.tx   = ~r.last;
            n.last = ~r.last;
            n.scnt = 3'h1;
          end else begin
            if (r.st == S_FRAME && r.pos != r.len) begin
              b     = r.frm[FRAME_W-1];
              n.frm = {r.frm[FRAME_W-2:0], 1'h0};
              n.crc = crc_step(r.crc, b);
              n.pos = 7'(r.pos + 7'h01);
            end else if (r.st == S_FRAME || r.pos != CRC_BITS) begin
              b     = r.crc[CRC_W-1];
              n.crc = {r.crc[CRC_W-2:0], 1'h0};
              n.st  = S_CRC;
              n.pos = (r.st == S_FRAME) ? 7'h01 : 7'(r.pos + 7'h01);
            end else begin
              n.st  = S_TAIL;
              n.pos = 7'h01;
            end
            n.tx   = b;
            n.scnt = (b == r.last) ? 3'(r.scnt + 3'h1) : 3'h1;
            n.last = b;
          end
        end
        S_TAIL: begin
          n.tx = RECESSIVE;
          if (r.pos == TAIL_BITS) begin
            n.empty[r.sel] = 1'h1;
            n.done[r.sel]  = 1'h1;
            n.st  = S_IFS;
            n.pos = 7'h01;
          end else begin
            n.pos = 7'(r.pos + 7'h01);
          end
        end
        S_IFS: begin
          n.tx = RECESSIVE;
          if (r.pos == IFS_BITS) begin
            n.st   = S_IDLE;
            n.idle = IDLE_BITS;
          end else begin
            n.pos = 7'(r.pos + 7'h01);
          end
        end
        default: n.tx = RECESSIVE;
      endcase
    end
    n.po  = {gpio_data, n.tx, 1'h0};
    n.poe = {gpio_dir, 1'h1, 1'h0};
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      r       <= '0;
      r.tx    <= RECESSIVE;
      r.last  <= RECESSIVE;
      r.rxs   <= '1;
      r.rx    <= RECESSIVE;
      r.empty <= '1;
      r.po    <= 8'h02;
      r.poe   <= 8'h02;
    end else if (ce) begin
      r <= n;
    end
  end

  assign port_o                     = r.po;
  assign port_oe                    = r.poe;
  assign gpio_in                    = r.gin;
  assign transmit_buffer_empty_flag = r.empty;
  assign tx_done                    = r.done;
  assign tx_abort                   = r.abort;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  sequence ifs_end;
    ce && r.st == S_IFS && r.pos == IFS_BITS && bnd && (|pend);
  endsequence

  a_idle_recessive: assert property (r.st == S_IDLE |-> r.tx && port_o[TX_BIT])
    else $error("transmit pin not recessive while idle");
  a_pin_map: assert property (!port_oe[RX_BIT] && port_oe[TX_BIT] && port_o[TX_BIT] == r.tx)
    else $error("receive or transmit pin mapped wrongly");
  a_gpio_follow: assert property (ce |=> port_oe[7:2] == $past(gpio_dir) && port_o[7:2] == $past(gpio_data))
    else $error("general purpose pins do not follow their controls");
  a_frame_length: assert property (start && ce |=> r.len >= (r.ide[r.sel] ? EXT_HDR : STD_HDR) && r.len <= (r.ide[r.sel] ? EXT_HDR : STD_HDR) + 7'h40)
    else $error("frame length outside format limits");
  a_reload_busy: assert property (ce && r.st != S_IDLE && load && load_idx != r.sel && load_idx != 2'h3 && r.empty[load_idx] |=> r.id[$past(load_idx)] == $past(load_id) && r.st != S_IDLE || $past(n.abort))
    else $error("buffer reload failed during transmission");
  a_local_priority_field_pick: assert property (start |-> pend[best] && (!pend[0] || r.local_priority_field[best] <= r.local_priority_field[0]) && (!pend[1] || r.local_priority_field[best] <= r.local_priority_field[1]) && (!pend[2] || r.local_priority_field[best] <= r.local_priority_field[2]))
    else $error("selected buffer is not the highest priority");
  a_back_to_back: assert property (ifs_end |=> r.st == S_FRAME && r.tx == DOMINANT ##1 r.st == S_FRAME [*3])
    else $error("bus released between frames");
  a_done_empty: assert property (ce && bnd && r.st == S_TAIL && r.pos == TAIL_BITS |=> r.done[r.sel] && r.empty[r.sel])
    else $error("successful buffer not flagged empty");
  a_ready_clears: assert property (ce && |(mark_ready & r.empty) |=> (r.empty & $past(mark_ready & r.empty)) == '0)
    else $error("ready mark did not clear empty flag");
endmodule

/* pkg/cpt_pkg.sv */
// Constants and types shared by the CAN pin interface and transmit queue
package cpt_pkg;
  // ----------------------------------------------------------------
  // Port CAN pin map
  // ----------------------------------------------------------------
  localparam int          PORT_W    = 8;
  localparam int          RX_BIT    = 0;
  localparam int          TX_BIT    = 1;
  localparam int          GPIO_LSB  = 2;
  localparam int          GPIO_W    = 6;
  localparam logic        DOMINANT  = 1'h0;
  localparam logic        RECESSIVE = 1'h1;
  // ----------------------------------------------------------------
  // Transmit buffers and frame layout
  // ----------------------------------------------------------------
  localparam int          NBUF      = 3;
  localparam int          ID_W      = 29;
  localparam int          LOCAL_PRIORITY_FIELD_W    = 8;
  localparam int          DATA_W    = 64;
  localparam int          FRAME_W   = 103;
  localparam logic [6:0]  STD_HDR   = 7'h13;
  localparam logic [6:0]  EXT_HDR   = 7'h27;
  localparam logic [3:0]  MAX_DLC   = 4'h8;
  localparam int          CRC_W     = 15;
  localparam logic [14:0] CRC_POLY  = 15'h4599;
  localparam logic [6:0]  CRC_BITS  = 7'h0f;
  localparam logic [2:0]  STUFF_MAX = 3'h5;
  localparam logic [6:0]  ACK_SLOT  = 7'h02;
  localparam logic [6:0]  TAIL_BITS = 7'h0a;
  localparam logic [6:0]  IFS_BITS  = 7'h03;
  localparam logic [3:0]  IDLE_BITS = 4'hb;
  // ----------------------------------------------------------------
  // Bit timing
  // ----------------------------------------------------------------
  localparam int          CLK_PERIOD_NS  = 4;
  localparam int          BIT_TIME_NS    = 1000;
  localparam int          BIT_CYCLES_DEF = BIT_TIME_NS / CLK_PERIOD_NS;
  localparam int          SAMPLE_NUM     = 5;
  localparam int          SAMPLE_DEN     = 8;
  // ----------------------------------------------------------------
  // Transmitter states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_FRAME = 3'b001,
    S_CRC   = 3'b010,
    S_TAIL  = 3'b011,
    S_IFS   = 3'b100
  } cpt_state_t;
endpackage

/* dv/cpt_xcvr.sv */
// Behavioural transceiver with one remote node that loops the bus back and acknowledges
`timescale 1ns/1ps
module cpt_xcvr #(
  parameter int BC = 16
) (
  input  wire logic        ref_clk,
  input  wire logic        tx,
  input  wire logic        ack_en,
  output logic             rx,
  output logic [39:0]      frame_bits
);
  int         ph   = 0;
  int         n    = 0;
  int         run  = 0;
  int         len  = 999;
  logic       busy = 1'b0;
  logic       last = 1'b1;
  logic       drv  = 1'b0;
  logic       b;
  logic       rtr;
  logic [3:0] dlc;
  // Wired bus: a low level from either side wins
  assign rx = tx & ~drv;
  always @(posedge ref_clk) begin
    if (!busy) begin
      if (tx === 1'b0) begin
        busy       = 1'b1;
        ph         = 0;
        n          = 0;
        run        = 0;
        last       = 1'b1;
        len        = 999;
        frame_bits = '0;
      end
    end else begin
      ph = ph + 1;
      if (ph == BC) begin
        ph = 0;
        // Ack slot follows the delimiter; dropped when told to withhold it
        drv <= ack_en && n == len + 1;
        if (n == len + 2) begin
          busy = 1'b0;
        end
      end
      if (ph == BC / 2) begin
        b = rx;
        if (n <= len && run == 5) begin
          // Stuff bit; an equal level means the sender gave up the frame
          if (b == last) begin
            busy = 1'b0;
          end
          run = 1;
        end else begin
          n   = n + 1;
          run = (b == last) ? run + 1 : 1;
          if (n <= 40) begin
            frame_bits[40-n] = b;
          end
          if (n == (frame_bits[26] ? 39 : 19)) begin
            dlc = frame_bits[26] ? frame_bits[4:1] : frame_bits[24:21];
            rtr = frame_bits[26] ? frame_bits[7] : frame_bits[27];
            len = n + 15 + (rtr ? 0 : 8 * ((dlc > 8) ? 8 : int'(dlc)));
          end
        end
        last = b;
      end
    end
  end
endmodule

/* dv/tb_cpt_ctrl.sv */
// Self-checking bench for the CAN pin interface and transmit queue
`timescale 1ns/1ps
module tb_cpt_ctrl;
  import cpt_pkg::*;
  // --------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------
  logic              ref_clk      = 1'b0;
  logic              srst         = 1'b1;
  logic              ce           = 1'b1;
  logic              load         = 1'b0;
  logic              load_ide     = 1'b0;
  logic              ack_en       = 1'b1;
  logic [1:0]        load_idx     = 2'h0;
  logic [ID_W-1:0]   load_id      = '0;
  logic [3:0]        load_dlc     = 4'h0;
  logic [LOCAL_PRIORITY_FIELD_W-1:0] load_local_priority_field    = 8'h00;
  logic [NBUF-1:0]   mark_ready   = 3'h0;
  logic [GPIO_W-1:0] gpio_data    = 6'h00;
  logic [GPIO_W-1:0] gpio_dir     = 6'h00;
  logic [GPIO_W-1:0] pin_hi       = 6'h00;
  logic              rx;
  logic              tx_abort;
  logic [PORT_W-1:0] port_o;
  logic [PORT_W-1:0] port_oe;
  logic [GPIO_W-1:0] gpio_in;
  logic [NBUF-1:0]   empty;
  logic [NBUF-1:0]   tx_done;
  logic [39:0]       frame_bits;
  int                miscompares  = 0;
  int                total_checks = 0;
  int                cycles       = 0;
  // --------------------------------------------------------------
  // Design, far side, clock and watchdog
  // --------------------------------------------------------------
  cpt_ctrl #(.BIT_CYCLES(16'h0010)) cpt_ctrl_i (
    .ref_clk(ref_clk), .srst(srst), .ce(ce), .port_i({pin_hi, 1'b1, rx}),
    .port_o(port_o), .port_oe(port_oe), .gpio_data(gpio_data), .gpio_dir(gpio_dir),
    .gpio_in(gpio_in), .load(load), .load_idx(load_idx), .load_id(load_id),
    .load_ide(load_ide), .load_rtr(1'b0), .load_dlc(load_dlc),
    .load_data(64'ha5c3_0000_0000_0000), .load_local_priority_field(load_local_priority_field),
    .mark_ready(mark_ready), .transmit_buffer_empty_flag(empty), .tx_done(tx_done),
    .tx_abort(tx_abort));
  cpt_xcvr #(.BC(16)) cpt_xcvr_i (
    .ref_clk(ref_clk), .tx(port_o[TX_BIT]), .ack_en(ack_en), .rx(rx),
    .frame_bits(frame_bits));
  initial begin
    forever #2 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 60000) begin
      miscompares++;
      conclude();
    end
  end
  // --------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------
  task automatic conclude();
    if (miscompares == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic ld(input int idx, input logic [28:0] id, input logic ide, input logic [7:0] pr,
                    input logic go = 1'b1);
    @(negedge ref_clk);
    load       = 1'b1;
    load_idx   = 2'(idx);
    load_id    = id;
    load_ide   = ide;
    load_dlc   = ide ? 4'h0 : 4'h1;
    load_local_priority_field  = pr;
    mark_ready = go ? 3'(1 << idx) : 3'h0; // Ready marks the loaded buffer
    @(negedge ref_clk);
    load       = 1'b0;
    mark_ready = 3'h0;
  endtask
  task automatic exp_frame(input int idx, input logic [28:0] id, input logic ide);
    for (int i = 0; i < 4000 && tx_done === 3'h0; i++)
      @(negedge ref_clk);
    chk("done_index", 64'(tx_done), 64'(1 << idx));
    chk("empty_set", 64'(empty[idx]), 64'h1);
    if (ide)
      chk("ext_hdr", 64'(frame_bits[39:1]), 64'({1'b0, id[28:18], 2'b11, id[17:0], 7'h00}));
    else
      chk("std_hdr", 64'(frame_bits[39:21]), 64'({1'b0, id[10:0], 7'h01}));
  endtask
  task automatic gap();
    int g;
    g = 0;
    while (port_o[TX_BIT] !== DOMINANT && g < 200) begin
      @(negedge ref_clk);
      g++;
    end
    chk("frame_gap", 64'(g >= 46 && g <= 51), 64'h1);
  endtask
  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_reset();
    chk("port_o_rst", 64'(port_o), 64'h02);
    chk("port_oe_rst", 64'(port_oe), 64'h02);
    chk("empty_rst", 64'(empty), 64'h7);
  endtask
  task automatic t_gpio();
    @(negedge ref_clk);
    ce        = 1'b0;
    gpio_data = 6'h2d;
    gpio_dir  = 6'h36;
    pin_hi    = 6'h19;
    repeat (3) @(negedge ref_clk);
    chk("ce_freeze_o", 64'(port_o), 64'h02);
    chk("ce_freeze_in", 64'(gpio_in), 64'h00);
    ce        = 1'b1;
    repeat (8) @(negedge ref_clk);
    chk("gpio_out", 64'(port_o[7:2]), 64'h2d);
    chk("port_dir", 64'(port_oe), 64'({6'h36, 2'b10}));
    chk("gpio_in", 64'(gpio_in), 64'h19);
    chk("rx_undriven", 64'(port_o[RX_BIT]), 64'h0);
  endtask
  task automatic t_single();
    ld(0, 29'h0000_0123, 1'b0, 8'h00);
    chk("empty_clr", 64'(empty), 64'h6);
    exp_frame(0, 29'h0000_0123, 1'b0);
    ld(2, 29'h0abc_1234, 1'b1, 8'h00);
    exp_frame(2, 29'h0abc_1234, 1'b1);
  endtask
  task automatic t_local_priority_field();
    // All three made pending at one edge so no boundary can pick early
    ld(0, 29'h0000_0301, 1'b0, 8'h30, 1'b0);
    ld(1, 29'h0000_0102, 1'b0, 8'h10, 1'b0);
    ld(2, 29'h0000_0203, 1'b0, 8'h20, 1'b0);
    @(negedge ref_clk);
    mark_ready = 3'h7;
    @(negedge ref_clk);
    mark_ready = 3'h0;
    chk("all_pending", 64'(empty), 64'h0);
    exp_frame(1, 29'h0000_0102, 1'b0);
    gap();
    // Buffer 1 reloaded with top priority while buffer 2 is on the bus
    ld(1, 29'h0000_0044, 1'b0, 8'h00);
    exp_frame(2, 29'h0000_0203, 1'b0);
    gap();
    exp_frame(1, 29'h0000_0044, 1'b0);
    gap();
    exp_frame(0, 29'h0000_0301, 1'b0);
  endtask
  task automatic t_noack();
    ack_en = 1'b0;
    ld(0, 29'h0000_0555, 1'b0, 8'h00);
    for (int i = 0; i < 4000 && tx_abort !== 1'b1; i++)
      @(negedge ref_clk);
    chk("abort", 64'(tx_abort), 64'h1);
    ack_en = 1'b1;
    chk("still_pending", 64'(empty[0]), 64'h0);
    ld(0, 29'h0000_0666, 1'b0, 8'h00);
    exp_frame(0, 29'h0000_0555, 1'b0);
  endtask
  initial begin
    repeat (6) @(negedge ref_clk);
    srst = 1'b0;
    t_reset();
    t_gpio();
    t_single();
    t_local_priority_field();
    t_noack();
    conclude();
  end
endmodule
